// ===== hdl/lii_pkg.sv
// Package for the local interrupt unit model-register slice.
// Assumes one core clock; the core issues one model-register access per cycle at most.
package lii_pkg;

  // ----------------------------------------
  // Model-register addresses
  // ----------------------------------------
  localparam logic [11:0] LII_ADDR_LOG_DEST  = 12'h80D;
  localparam logic [11:0] LII_ADDR_ERR_FLAGS = 12'h828;
  localparam logic [11:0] LII_ADDR_INT_CMD   = 12'h830;
  localparam logic [11:0] LII_ADDR_OWN_INT   = 12'h83F;

  // ----------------------------------------
  // Error flag positions and command fields
  // ----------------------------------------
  localparam int LII_ERR_SEND_ILL_POS   = 5;
  localparam int LII_ERR_RECV_ILL_POS   = 6;
  localparam int LII_ERR_ILL_ADDR_POS   = 7;
  localparam int LII_ERR_REDIR_POS      = 4;
  localparam logic [31:0] LII_ERR_RESET = 32'h0000_0000;
  localparam logic [7:0]  LII_VEC_ILL_MAX = 8'h0F;
  localparam logic [2:0]  LII_DLV_FIXED   = 3'h0;
  localparam logic [2:0]  LII_DLV_LOWPRI  = 3'h1;
  localparam logic [1:0]  LII_SH_SELF     = 2'h1;
  localparam logic [31:0] LII_DEST_BCAST  = 32'hFFFF_FFFF;
  // Writable bits of command low word: vector, mode, dest mode, level, trigger, shorthand
  localparam logic [31:0] LII_CMD_LO_MASK = 32'h000C_CFFF;
  localparam logic [31:0] LII_OWN_MASK    = 32'h0000_00FF;
  // Command word and unit ID field positions
  localparam int LII_CMD_VEC_LSB    = 0;
  localparam int LII_CMD_MODE_LSB   = 8;
  localparam int LII_CMD_LOG_POS    = 11;
  localparam int LII_CMD_TRIG_POS   = 15;
  localparam int LII_CMD_SH_LSB     = 18;
  localparam int LII_ID_MEMBER_LSB  = 0;
  localparam int LII_ID_CLUSTER_LSB = 4;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic [63:0] wdata;
  } lii_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] dest;
    logic [1:0]  shorthand;
    logic        level_trig;
    logic        logical;
    logic [2:0]  mode;
    logic [7:0]  vector;
  } lii_ipi_t;

endpackage

// ===== hdl/lii_core.sv
// Local interrupt unit: extended-ID model-register slice (error flags, command, logical dest, own-core).
// Assumes the core holds a request one cycle and samples ack, fault and read data in the cycle after it.
// How it works
// RL1 - Reserved address or reserved-bit access in extended-ID mode raises a fault.
// RL2 - Non-zero write to error flags faults; detected errors are recorded there.
// RL3 - Command or own-core write with vector 0FH or below sets send-illegal.
// RL4 - Incoming vector 0FH or below is dropped and only sets receive-illegal.
// RL5 - Lowest-priority command write sets redirectible flag and is not sent.
// RL6 - Lowest-priority plus illegal vector sets only the redirectible flag.
// RL7 - Command low word lacks delivery status; destination is 32 bits wide.
// RL8 - One write to the command register dispatches the interrupt.
// RL9 - Command read-back is for debug only; requester must not trust it.
// RL10 - All-ones destination is broadcast in logical and physical modes.
// RL11 - Logical destination is 32-bit, read-only, read at 80DH.
// RL12 - No flat logical mode; destination format register is absent.
// RL13 - Logical destination: cluster in upper 16 bits, one-hot member in lower.
// RL14 - Unimplemented cluster or member bits read as zero.
// RL15 - Logical destination is ID[19:4] in top half, one shifted by ID[3:0].
// RL16 - Logical destination reloads whenever extended-ID mode becomes enabled.
// RL17 - Own-core register at 083FH holds an 8-bit vector, upper bits reserved.
// RL18 - Own-core write acts as self, edge, fixed send with the written vector.
// RL19 - Own-core register is write-only; reading it faults.
// RL20 - Own-core write completes only with the request bit already set.
// RL21 - Self-sent interrupts are tracked like bus-received ones.
// RL22 - Same-vector edge interrupts may merge into one pending request.
// RL23 - Error flag positions are parameters with the legacy layout.
`timescale 1ns/1ps

module lii_core
  import lii_pkg::*;
#(
  parameter int CLUSTER_BITS  = 16,
  parameter int MEMBER_BITS   = 16,
  parameter int ERR_SEND_POS  = LII_ERR_SEND_ILL_POS,
  parameter int ERR_RECV_POS  = LII_ERR_RECV_ILL_POS,
  parameter int ERR_ADDR_POS  = LII_ERR_ILL_ADDR_POS,
  parameter int ERR_REDIR_POS = LII_ERR_REDIR_POS
)
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // Mode and identity
  input  wire logic         ext_mode_i,
  input  wire logic [31:0]  unit_id_i,
  // Model-register access from the core
  input  wire lii_req_t     req_i,
  output logic              ack_o,
  output logic              fault_o,
  output logic [63:0]       rdata_o,
  // Incoming interrupts from the system bus
  input  wire logic         rx_valid_i,
  input  wire logic [7:0]   rx_vector_i,
  input  wire logic         rx_level_i,
  // Outgoing interrupt messages
  output lii_ipi_t          ipi_o,
  output logic              ipi_bcast_o,
  // Request and trigger tracking
  input  wire logic [255:0] accept_clr_i,
  output logic [255:0]      req_pending_o,
  output logic [255:0]      trig_kind_o
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (CLUSTER_BITS < 1 || CLUSTER_BITS > 16 || MEMBER_BITS < 1 || MEMBER_BITS > 16)
  begin : g_bad_width
    $error("lii_core: cluster and member widths must be 1..16");
  end

  if (ERR_SEND_POS < 0 || ERR_SEND_POS > 31 || ERR_RECV_POS < 0 || ERR_RECV_POS > 31 ||
      ERR_ADDR_POS < 0 || ERR_ADDR_POS > 31 || ERR_REDIR_POS < 0 || ERR_REDIR_POS > 31)
  begin : g_bad_err_pos
    $error("lii_core: error flag positions must be 0..31");
  end

  // A shared position would hide which error happened
  if (ERR_SEND_POS == ERR_RECV_POS || ERR_SEND_POS == ERR_ADDR_POS || ERR_SEND_POS == ERR_REDIR_POS ||
      ERR_RECV_POS == ERR_ADDR_POS || ERR_RECV_POS == ERR_REDIR_POS || ERR_ADDR_POS == ERR_REDIR_POS)
  begin : g_same_err_pos
    $error("lii_core: error flag positions must differ");
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic logic vec_illegal(input logic [7:0] v);
    vec_illegal = (v <= LII_VEC_ILL_MAX);
  endfunction

  logic [31:0]  err_ff;
  logic [31:0]  nxt_err;
  logic [31:0]  cmd_lo_ff;
  logic [31:0]  cmd_hi_ff;
  logic [31:0]  log_dest_ff;
  logic [31:0]  nxt_log_dest;
  logic         ext_d_ff;
  logic [255:0] pend_ff;
  logic [255:0] trig_ff;
  lii_ipi_t     ipi_ff;
  lii_ipi_t     nxt_ipi;
  logic         bcast_ff;
  logic         ack_ff;
  logic         fault_ff;
  logic [63:0]  rdata_ff;

  wire acc      = req_i.valid & ext_mode_i;
  wire is_wr    = acc & req_i.write;
  wire is_rd    = acc & ~req_i.write;
  wire hit_ld   = (req_i.addr == LII_ADDR_LOG_DEST);
  wire hit_err  = (req_i.addr == LII_ADDR_ERR_FLAGS);
  wire hit_cmd  = (req_i.addr == LII_ADDR_INT_CMD);
  wire hit_own  = (req_i.addr == LII_ADDR_OWN_INT);
  wire [31:0] wlo = req_i.wdata[31:0];
  wire [31:0] whi = req_i.wdata[63:32];

  // Command fields of the low word; the own-core vector shares bits 7..0
  wire [7:0]  cmd_vec     = wlo[LII_CMD_VEC_LSB +: 8];
  wire [2:0]  cmd_mode    = wlo[LII_CMD_MODE_LSB +: 3];
  wire        cmd_logical = wlo[LII_CMD_LOG_POS];
  wire        cmd_level   = wlo[LII_CMD_TRIG_POS];
  wire [1:0]  cmd_sh      = wlo[LII_CMD_SH_LSB +: 2];
  wire        cmd_bcast   = (whi == LII_DEST_BCAST);                          // [RL10]

  wire bad_addr   = ~(hit_ld | hit_err | hit_cmd | hit_own);                  // [RL1] [RL12]
  wire wr_resv    = (hit_cmd & |(wlo & ~LII_CMD_LO_MASK))
                  | (hit_own & |({whi, wlo & ~LII_OWN_MASK}))                 // [RL17]
                  | (hit_err & |req_i.wdata);                                 // [RL2]
  wire wr_ro      = hit_ld;                                                   // [RL11]
  wire rd_wo      = hit_own;                                                  // [RL19]
  wire flt        = (is_wr & (bad_addr | wr_resv | wr_ro)) | (is_rd & (bad_addr | rd_wo)); // [RL1]
  wire cmd_go     = is_wr & hit_cmd & ~flt;                                   // [RL8]
  wire own_go     = is_wr & hit_own & ~flt;
  wire cmd_lowpri = (cmd_mode == LII_DLV_LOWPRI);
  wire cmd_ill    = vec_illegal(cmd_vec);
  wire cmd_send   = cmd_go & ~cmd_lowpri & ~cmd_ill;                          // [RL5] [RL8]
  wire [7:0] own_vec = cmd_vec;
  wire own_ok     = own_go & ~vec_illegal(own_vec);
  wire rx_ok      = rx_valid_i & ~vec_illegal(rx_vector_i);                   // [RL4]

  // Error events; lowest priority masks the send-illegal event
  wire ev_redir    = cmd_go & cmd_lowpri;                                     // [RL5] [RL6]
  wire ev_send_ill = (cmd_go & ~cmd_lowpri & cmd_ill) | (own_go & ~own_ok);   // [RL3] [RL6]
  wire ev_recv_ill = rx_valid_i & ~rx_ok;                                     // [RL4]
  wire ev_ill_addr = acc & bad_addr;                                          // [RL2]

  // ----------------------------------------
  // Error flags
  // ----------------------------------------
  always_comb
  begin
    nxt_err = err_ff;
    if (ev_redir)
      nxt_err[ERR_REDIR_POS] = 1'b1;                                          // [RL5] [RL6]
    if (ev_send_ill)
      nxt_err[ERR_SEND_POS] = 1'b1;                                           // [RL3] [RL23]
    if (ev_recv_ill)
      nxt_err[ERR_RECV_POS] = 1'b1;                                           // [RL4]
    if (ev_ill_addr)
      nxt_err[ERR_ADDR_POS] = 1'b1;                                           // [RL2]
  end

  // ----------------------------------------
  // Logical destination
  // ----------------------------------------
  wire [15:0] ld_cluster = unit_id_i[LII_ID_CLUSTER_LSB +: 16];
  wire [15:0] ld_member  = 16'h0001 << unit_id_i[LII_ID_MEMBER_LSB +: 4];     // [RL15]
  wire        ext_rise   = ext_mode_i & ~ext_d_ff;                            // [RL16]
  wire [15:0] cl_mask    = 16'hFFFF >> (16 - CLUSTER_BITS);
  wire [15:0] mb_mask    = 16'hFFFF >> (16 - MEMBER_BITS);
  assign nxt_log_dest = {ld_cluster & cl_mask, ld_member & mb_mask};          // [RL13] [RL14]

  // ----------------------------------------
  // Outgoing message
  // ----------------------------------------
  always_comb
  begin
    nxt_ipi = '0;
    if (cmd_send)
    begin
      nxt_ipi.valid      = 1'b1;                                              // [RL8]
      nxt_ipi.dest       = whi;                                               // [RL7]
      nxt_ipi.shorthand  = cmd_sh;
      nxt_ipi.level_trig = cmd_level;
      nxt_ipi.logical    = cmd_logical;
      nxt_ipi.mode       = cmd_mode;
      nxt_ipi.vector     = cmd_vec;
    end
  end

  // ----------------------------------------
  // Request and trigger set masks
  // ----------------------------------------
  // One comparator per vector instead of a 256-bit shifter
  wire [255:0] own_set;
  wire [255:0] rx_set;
  for (genvar v = 0; v < 256; v++)
  begin : g_vec
    assign own_set[v] = own_ok & (own_vec == 8'(v));                          // [RL18] [RL20]
    assign rx_set[v]  = rx_ok & (rx_vector_i == 8'(v));                       // [RL21]
  end
  wire [255:0] rx_lvl  = rx_level_i ? rx_set : '0;

  // ----------------------------------------
  // Read data selection
  // ----------------------------------------
  // Faulting reads and all writes answer zero
  wire        rd_ok     = is_rd & ~flt;
  wire [63:0] nxt_rdata = !rd_ok  ? 64'h0 :
                          hit_ld  ? {32'h0, log_dest_ff} :                    // [RL11] [RL14]
                          hit_err ? {32'h0, err_ff} :
                          hit_cmd ? {cmd_hi_ff, cmd_lo_ff} :                  // [RL9]
                          64'h0;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Error flags are only ever set here; reset is their one clear
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      err_ff   <= LII_ERR_RESET;
      ipi_ff   <= '0;
      bcast_ff <= 1'b0;
    end
    else
    begin
      err_ff   <= nxt_err;
      ipi_ff   <= nxt_ipi;
      bcast_ff <= nxt_ipi.valid & cmd_bcast;                                  // [RL10]
    end
  end

  // Logical destination follows each rise of extended-ID mode
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ext_d_ff    <= 1'b0;
      log_dest_ff <= '0;
    end
    else
    begin
      ext_d_ff <= ext_mode_i;
      if (ext_rise)
        log_dest_ff <= nxt_log_dest;                                          // [RL16]
    end
  end

  // Command word kept only for debug read-back
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cmd_lo_ff <= '0;
      cmd_hi_ff <= '0;
    end
    else if (cmd_go)
    begin
      cmd_lo_ff <= wlo & LII_CMD_LO_MASK;                                     // [RL7]
      cmd_hi_ff <= whi;
    end
  end

  // Set wins over accept-clear so a same-cycle arrival survives
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pend_ff <= '0;
      trig_ff <= '0;
    end
    else
    begin
      pend_ff <= (pend_ff & ~accept_clr_i) | own_set | rx_set;                // [RL21] [RL22]
      trig_ff <= (trig_ff & ~(own_set | rx_set)) | rx_lvl;                    // [RL18]
    end
  end

  // Answer registered so read data comes from flip-flops
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ack_ff   <= 1'b0;
      fault_ff <= 1'b0;
      rdata_ff <= '0;
    end
    else
    begin
      ack_ff   <= acc;
      fault_ff <= flt;
      rdata_ff <= nxt_rdata;                                                  // [RL11]
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign ack_o         = ack_ff;
  assign fault_o       = fault_ff;
  assign rdata_o       = rdata_ff;
  assign ipi_o         = ipi_ff;
  assign ipi_bcast_o   = bcast_ff;
  assign req_pending_o = pend_ff;
  assign trig_kind_o   = trig_ff;

endmodule

// ===== verif/lii_core_assertions.sv
// Checker of lii_core access answers, faults and outgoing messages.
// Assumes it is bound to lii_core and sees only its ports.
`timescale 1ns/1ps
module lii_core_chk
  import lii_pkg::*;
(
  // Clock, reset and mode
  input wire logic         clk_i,
  input wire logic         rst_b_i,
  input wire logic         ext_mode_i,
  // Access and answers
  input wire lii_req_t     req_i,
  input wire logic         ack_o,
  input wire logic         fault_o,
  input wire lii_ipi_t     ipi_o,
  input wire logic         ipi_bcast_o,
  input wire logic [255:0] req_pending_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire        acc = req_i.valid && ext_mode_i;
  wire        wr  = acc && req_i.write;
  wire [11:0] ad  = req_i.addr;
  wire [31:0] lo  = req_i.wdata[31:0];
  wire        cmd = wr && ad == LII_ADDR_INT_CMD;
  wire        own = wr && ad == LII_ADDR_OWN_INT && req_i.wdata[63:8] == '0 && lo[7:0] > LII_VEC_ILL_MAX;
  // Only clean fixed sends get a content check; lowest priority is checked only for being dropped
  wire        good = cmd && (lo & ~LII_CMD_LO_MASK) == '0 && lo[10:8] == LII_DLV_FIXED && lo[7:0] > LII_VEC_ILL_MAX;
  wire        unmap = acc && !(ad inside {LII_ADDR_LOG_DEST, LII_ADDR_ERR_FLAGS, LII_ADDR_INT_CMD, LII_ADDR_OWN_INT});
  a_ack_next: assert property (acc |=> ack_o) else $error("ack missing");
  a_unmap_fault: assert property (unmap |=> fault_o) else $error("unmapped access not faulted");
  a_err_wr_fault: assert property (wr && ad == LII_ADDR_ERR_FLAGS && lo != '0 |=> fault_o)
    else $error("error flags write not faulted");
  a_ldr_wr_fault: assert property (wr && ad == LII_ADDR_LOG_DEST |=> fault_o)
    else $error("logical dest write not faulted");
  a_own_rd_fault: assert property (acc && !req_i.write && ad == LII_ADDR_OWN_INT |=> fault_o)
    else $error("own-core read not faulted");
  a_own_pending: assert property (own |=> req_pending_o[$past(lo[7:0])] && !fault_o)
    else $error("own-core vector not pending at ack");
  a_lowpri_drop: assert property (cmd && lo[10:8] == LII_DLV_LOWPRI |=> !ipi_o.valid)
    else $error("lowest priority message sent");
  a_cmd_sends: assert property (good |=> ipi_o.valid && ipi_o.vector == $past(lo[7:0])
    && ipi_o.dest == $past(req_i.wdata[63:32])) else $error("command message wrong");
  a_bcast_flag: assert property (ipi_bcast_o == (ipi_o.valid && ipi_o.dest == LII_DEST_BCAST))
    else $error("broadcast flag wrong");
endmodule
bind lii_core lii_core_chk u_chk (.clk_i, .rst_b_i, .ext_mode_i, .req_i, .ack_o, .fault_o, .ipi_o,
  .ipi_bcast_o, .req_pending_o);

// ===== verif/lii_host.sv
// Core-side model issuing one model-register access at a time.
// Assumes the bench calls access; answers are registered at the take edge and read half a cycle later.
`timescale 1ns/1ps
module lii_host
  import lii_pkg::*;
(
  // Clock and answers
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic        fault_i,
  input  wire logic [63:0] rdata_i,
  // Request
  output lii_req_t         req_o
);
  initial req_o = '0;
  // Command read-back never trusted, so it is never read here
  task automatic access(input logic w, input logic [11:0] a, input logic [63:0] d,
                        output logic f, output logic [63:0] q);
    @(negedge clk_i);
    req_o = '{1'h1, w, a, d};
    @(negedge clk_i);
    // Missing ack shows as unknown fault
    f = ack_i ? fault_i : 1'hx;
    q = rdata_i;
    // Released fields turn over so stale values cannot pass
    req_o = '{1'h0, ~w, ~a, ~d};
  endtask
endmodule

// ===== verif/tb_top.sv
// Bench for lii_core: faults, error flags, logical dest, own-core and command sends.
// Assumes lii_host drives the access port and lii_core_chk is bound.
`timescale 1ns/1ps
module tb_top
  import lii_pkg::*;
;
  logic         clk_i = 1'h0, rst_b_i = 1'h0, ext_mode_i = 1'h0, rx_valid_i = 1'h0, rx_level_i = 1'h0, f;
  logic [31:0]  unit_id_i = 32'h0012_345A;
  logic [7:0]   rx_vector_i = 8'h00;
  logic [255:0] accept_clr_i = '0, req_pending_o, trig_kind_o;
  logic [63:0]  q, rdata_o;
  logic         ack_o, fault_o, ipi_bcast_o;
  lii_req_t     req_i;
  lii_ipi_t     ipi_o;
  int           n_mismatch = 0, compares = 0;
  always #5 clk_i = ~clk_i;
  lii_core uut (.clk_i, .rst_b_i, .ext_mode_i, .unit_id_i, .req_i, .ack_o, .fault_o, .rdata_o, .rx_valid_i,
    .rx_vector_i, .rx_level_i, .ipi_o, .ipi_bcast_o, .accept_clr_i, .req_pending_o, .trig_kind_o);
  lii_host h (.clk_i, .ack_i(ack_o), .fault_i(fault_o), .rdata_i(rdata_o), .req_o(req_i));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic finish_test;
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic xs(input logic w, input logic [11:0] a, input logic [63:0] d, input logic fe);
    h.access(w, a, d, f, q);
    check("fault", 64'(f), 64'(fe));
  endtask
  task automatic rx(input logic [7:0] v, input logic l);
    @(negedge clk_i);
    rx_valid_i = 1'h1;
    rx_vector_i = v;
    rx_level_i = l;
    @(negedge clk_i);
    rx_valid_i = 1'h0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_ldr;
    xs(1'h0, LII_ADDR_LOG_DEST, '0, 1'h0);
    check("ldr", q, 64'h0000_0000_2345_0400);
    xs(1'h1, LII_ADDR_LOG_DEST, 64'h1, 1'h1);
    ext_mode_i = 1'h0;
    unit_id_i = 32'h0000_0013;
    @(negedge clk_i);
    ext_mode_i = 1'h1;
    xs(1'h0, LII_ADDR_LOG_DEST, '0, 1'h0);
    check("ldr2", q, 64'h0000_0000_0001_0008);
  endtask
  task automatic t_own;
    xs(1'h1, LII_ADDR_OWN_INT, 64'h40, 1'h0);
    check("own_pend", 64'({req_pending_o[8'h40], trig_kind_o[8'h40]}), 64'h2);
    accept_clr_i[8'h40] = 1'h1;
    @(negedge clk_i);
    accept_clr_i = '0;
    check("own_clr", 64'(req_pending_o[8'h40]), 64'h0);
    xs(1'h0, LII_ADDR_OWN_INT, '0, 1'h1);
    xs(1'h1, LII_ADDR_OWN_INT, 64'h140, 1'h1);
  endtask
  task automatic t_err;
    logic [63:0] e;
    e = 64'h1 << LII_ERR_REDIR_POS;
    xs(1'h1, LII_ADDR_INT_CMD, 64'h105, 1'h0);
    check("lp_msg", 64'(ipi_o.valid), 64'h0);
    xs(1'h0, LII_ADDR_ERR_FLAGS, '0, 1'h0);
    check("err_lp", q, e);
    xs(1'h1, LII_ADDR_INT_CMD, 64'h005, 1'h0);
    e |= 64'h1 << LII_ERR_SEND_ILL_POS;
    xs(1'h0, LII_ADDR_ERR_FLAGS, '0, 1'h0);
    check("err_send", q, e);
    rx(8'h05, 1'h0);
    check("rx_ill", 64'(req_pending_o[8'h05]), 64'h0);
    rx(8'h50, 1'h1);
    check("rx_ok", 64'({req_pending_o[8'h50], trig_kind_o[8'h50]}), 64'h3);
    xs(1'h1, LII_ADDR_OWN_INT, 64'h50, 1'h0);
    check("merge", 64'({req_pending_o[8'h50], trig_kind_o[8'h50]}), 64'h2);
    xs(1'h0, 12'h80E, '0, 1'h1);
    e |= (64'h1 << LII_ERR_RECV_ILL_POS) | (64'h1 << LII_ERR_ILL_ADDR_POS);
    xs(1'h0, LII_ADDR_ERR_FLAGS, '0, 1'h0);
    check("err_all", q, e);
    xs(1'h1, LII_ADDR_ERR_FLAGS, 64'h1, 1'h1);
    xs(1'h1, LII_ADDR_ERR_FLAGS, 64'h0, 1'h0);
  endtask
  task automatic t_cmd;
    xs(1'h1, LII_ADDR_INT_CMD, 64'hFFFF_FFFF_0000_0830, 1'h0);
    check("msg", {ipi_o.valid, ipi_bcast_o, ipi_o.logical, ipi_o.mode, ipi_o.vector}, {3'h7, 3'h0, 8'h30});
    check("dest", 64'(ipi_o.dest), 64'hFFFF_FFFF);
    xs(1'h1, LII_ADDR_INT_CMD, 64'h0000_0007_0000_0031, 1'h0);
    check("msg2", {ipi_o.valid, ipi_bcast_o, ipi_o.dest}, {2'h2, 32'h7});
    xs(1'h1, LII_ADDR_INT_CMD, 64'h0000_0003_000C_C041, 1'h0);
    check("msg3", 64'({ipi_o.shorthand, ipi_o.level_trig, ipi_o.vector}), 64'h741);
    xs(1'h1, LII_ADDR_INT_CMD, 64'h1031, 1'h1);
  endtask
  initial
  begin
    repeat (20) @(negedge clk_i);
    check("rst", {ack_o, fault_o, ipi_o.valid, |req_pending_o}, 64'h0);
    rst_b_i = 1'h1;
    ext_mode_i = 1'h1;
    t_ldr;
    t_own;
    t_err;
    t_cmd;
    finish_test;
  end
  // Run needs about 64 cycles; the 1500-cycle limit is over twenty times that
  initial
  begin
    #15000;
    n_mismatch++;
    finish_test;
  end
endmodule
